// ===== src/sasc_pkg.sv
/*
  constants and types shared by the converter control block.
  assumes nothing beyond a systemverilog compiler.
*/
package sasc_pkg;
  // ****************************************
  // widths and counts
  // ****************************************
  localparam int RESULT_BITS = 14;
  localparam int CAL_CYCLES = 14000;
  localparam int ACQ_CYCLES = 3;
  localparam int ACQ_FULL = 4;
  localparam int CLK_HZ = 20000000;
  localparam real TSU_US = 3.2;
  localparam int TSU_CYC = int'((TSU_US * CLK_HZ + 999999.0) / 1000000.0);
  localparam logic [1:0] SEL_SHUTDOWN = 2'h0;
  localparam logic [1:0] SEL_UNIPOLAR = 2'h1;
  localparam logic [1:0] SEL_BIPOLAR = 2'h2;
  localparam logic [3:0] BIT_MSB = 4'hD;
  localparam logic [3:0] ACQ_SAT = 4'h3;
  localparam logic [3:0] ACQ_ONE = 4'h1;
  localparam logic [3:0] ZERO4 = 4'h0;

  // ****************************************
  // states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CAL = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_CONVERT_START_N = 4'b1000
  } sasc_state_t;
endpackage : sasc_pkg

// ===== src/sasc_sync.sv
/*
  two flip-flop synchroniser, one bit per lane.
  assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/10ps
module sasc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // lanes
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : sasc_sync

// ===== src/sasc_top.sv
/*
  control and serial readout of a successive-approximation converter.
  assumes the comparator decision arrives on compBit, clocked by mclk,
  and that the conversion clock and shift clock arrive as pins.
*/
// Notes on behaviour
// - low shutdown, high unipolar, float bipolar
// - shift clock may be asynchronous, between conversions
// - result leaves most significant bit first
// - end flag high through conversion or calibration
// - data driver enabled only under chip select
// - start on falling edge after acquisition completes
// - reset low holds converter inactive
// - reset rise starts 14000 cycle calibration
// - each conversion gives fourteen result bits
// - three idle cycles, else fourth edge
// - start pulses ignored during a conversion
// - read during conversion or by shift clock
`timescale 1ns/10ps
module sasc_top
  import sasc_pkg::*;
#(
  parameter int CAL_LEN = sasc_pkg::CAL_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // pins from the host
  input wire logic convClk,
  input wire logic shiftClk,
  input wire logic chipSel_n,
  input wire logic convert_start_n,
  input wire logic reset_n,
  input wire logic [1:0] range_shutdown_select,
  // comparator decision
  input wire logic compBit,
  // pins to the host
  output logic endOfConv,
  output logic dataOut,
  output logic dataOut_oe_n,
  output logic bipolar,
  output logic shutdown,
  output logic settled
);
  // ****************************************
  // input synchronisation
  // ****************************************
  logic [4:0] syncIn;
  logic cclkS, sclkS, csN, convN, rstN, cclkQ, sclkQ, rstQ;
  logic csAct, convAct;
  logic cclkFall, sclkFall, rstRise;
  logic [1:0] selS;

  // selects enter inverted so a flushed synchroniser reads as released
  sasc_sync #(.W(5)) u_sync (
    .clk(mclk),
    .rst(sys_rst),
    .din({convClk, shiftClk, !chipSel_n, !convert_start_n, reset_n}),
    .dout(syncIn)
  );
  assign {cclkS, sclkS, csAct, convAct, rstN} = syncIn;
  assign csN = !csAct;
  assign convN = !convAct;

  sasc_sync #(.W(2)) u_syncSel (
    .clk(mclk),
    .rst(sys_rst),
    .din(range_shutdown_select),
    .dout(selS)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cclkQ <= 1'b0;
      sclkQ <= 1'b0;
      rstQ <= 1'b0;
    end else begin
      cclkQ <= cclkS;
      sclkQ <= sclkS;
      rstQ <= rstN;
    end
  end
  assign cclkFall = cclkQ && !cclkS;
  assign sclkFall = sclkQ && !sclkS;
  assign rstRise = !rstQ && rstN;

  // ****************************************
  // range and shutdown decode
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shutdown <= 1'b1;
      bipolar <= 1'b0;
    end else begin
      shutdown <= (selS == SEL_SHUTDOWN);
      bipolar <= (selS == SEL_BIPOLAR);
    end
  end

  // settling helper only; the host owns the wait
  logic [15:0] setCnt;
  always_ff @(posedge mclk) begin
    if (sys_rst || shutdown) begin
      setCnt <= '0;
      settled <= 1'b0;
    end else if (setCnt < 16'(TSU_CYC)) begin
      setCnt <= setCnt + 16'h0001;
      settled <= 1'b0;
    end else begin
      settled <= 1'b1;
    end
  end

  // ****************************************
  // control state
  // ****************************************
  sasc_state_t state;
  logic [15:0] calCnt;
  logic [3:0] acqCnt, bitIdx;
  logic [RESULT_BITS-1:0] result;
  logic startReq;

  // start request latched until acquisition done; ignored while busy
  always_ff @(posedge mclk) begin
    if (sys_rst || !rstN || state == ST_CONVERT_START_N) begin
      startReq <= 1'b0;
    end else if (!convN && state != ST_CAL) begin
      startReq <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || !rstN) begin
      state <= ST_IDLE;
      calCnt <= '0;
      acqCnt <= ACQ_SAT;
      bitIdx <= BIT_MSB;
    end else if (rstRise) begin
      state <= ST_CAL;
      calCnt <= '0;
      acqCnt <= ACQ_SAT;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (startReq && !shutdown) begin
            state <= ST_WAIT;
          end
        end
        ST_CAL: begin
          if (cclkFall) begin
            if (calCnt == 16'(CAL_LEN - 1)) begin
              state <= ST_IDLE;
            end else begin
              calCnt <= calCnt + 16'h0001;
            end
          end
        end
        ST_WAIT: begin
          if (cclkFall) begin
            if (acqCnt >= ACQ_SAT) begin
              state <= ST_CONVERT_START_N;
              bitIdx <= BIT_MSB;
            end else begin
              acqCnt <= acqCnt + ACQ_ONE;
            end
          end
        end
        ST_CONVERT_START_N: begin
          if (cclkFall) begin
            if (bitIdx == ZERO4) begin
              state <= ST_IDLE;
              acqCnt <= ZERO4;
            end else begin
              bitIdx <= bitIdx - ACQ_ONE;
            end
          end
        end
      endcase
      // idle cycles after a conversion count toward acquisition
      if (state == ST_IDLE && cclkFall && acqCnt < ACQ_SAT) begin
        acqCnt <= acqCnt + ACQ_ONE;
      end
    end
  end

  // ****************************************
  // result register and serial output
  // ****************************************
  logic [3:0] shIdx;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      result <= '0;
      shIdx <= BIT_MSB;
      dataOut <= 1'b0;
    end else if (state == ST_CONVERT_START_N && cclkFall) begin
      result[bitIdx] <= compBit;
      dataOut <= compBit;
      shIdx <= BIT_MSB;
    end else if (state == ST_IDLE && !csN && sclkFall) begin
      dataOut <= result[shIdx];
      shIdx <= (shIdx == ZERO4) ? BIT_MSB : shIdx - ACQ_ONE;
    end else if (csN) begin
      shIdx <= BIT_MSB;
    end
  end

  assign dataOut_oe_n = csN;
  assign endOfConv = (state == ST_CAL) || (state == ST_CONVERT_START_N);

  // ****************************************
  // checks
  // ****************************************
  // fall counts kept apart from the control counters
  logic [3:0] idleFalls, convFalls;
  always_ff @(posedge mclk) begin
    if (sys_rst || !rstN) begin
      idleFalls <= 4'(ACQ_FULL);
    end else if (state == ST_CONVERT_START_N) begin
      idleFalls <= ZERO4;
    end else if (cclkFall && idleFalls < 4'(ACQ_FULL)) begin
      idleFalls <= idleFalls + ACQ_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || state != ST_CONVERT_START_N) begin
      convFalls <= ZERO4;
    end else if (cclkFall) begin
      convFalls <= convFalls + ACQ_ONE;
    end
  end

  eoc_in_reset_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !rstN |-> ##1 !endOfConv) else $error("end flag up in reset");
  cal_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rstRise |=> endOfConv) else $error("no calibration");
  oe_follow_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(chipSel_n, 2) && $past(chipSel_n) |-> dataOut_oe_n)
    else $error("driver without select");
  convert_start_n_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(state == ST_CONVERT_START_N) && rstN |-> convFalls == 4'(RESULT_BITS))
    else $error("conversion length wrong");
  no_restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state == ST_CONVERT_START_N && rstN && !rstRise && !cclkFall |=>
    state == ST_CONVERT_START_N) else $error("conversion disturbed");
  start_edge_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(state == ST_CONVERT_START_N) |-> $past(cclkFall))
    else $error("start off falling edge");
  acq_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(state == ST_CONVERT_START_N) |-> $past(idleFalls) >= 4'(ACQ_CYCLES))
    else $error("acquisition too short");
  shut_dec_a: assert property (@(posedge mclk) disable iff (sys_rst)
    selS == SEL_SHUTDOWN |=> shutdown) else $error("shutdown lost");
endmodule : sasc_top

// ===== verif/sasc_host.sv
/*
  host and comparator stand-in: conversion clock, shift clock, decisions.
  assumes the bench raises shiftOn only between conversions.
*/
`timescale 1ns/10ps
module sasc_host (
  // control from the bench
  input wire logic shiftOn,
  // pins
  output logic convClk,
  output logic shiftClk,
  output logic compBit
);
  initial begin
    convClk = 1'b1;
    compBit = 1'b0;
    forever begin
      #200 convClk = ~convClk;
      // change on rises, well clear of the sampling fall
      if (convClk) compBit = 1'($urandom_range(1));
    end
  end
  // shift clock rests low outside frames, own phase
  initial begin
    shiftClk = 1'b0;
    #137;
    forever begin
      #200 shiftClk = shiftOn ? ~shiftClk : 1'b0;
    end
  end
endmodule : sasc_host

// ===== verif/tb_top.sv
/*
  self-checking bench for the converter control block.
  assumes sasc_pkg, sasc_sync and sasc_top are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  import sasc_pkg::*;
  localparam int CAL = 20;
  logic mclk, sys_rst, shiftOn, chipSel_n, convert_start_n, reset_n;
  logic [1:0] range_shutdown_select;
  logic convClk, shiftClk, compBit, endOfConv, dataOut, dataOut_oe_n;
  logic bipolar, shutdown, settled;
  logic [13:0] bits;
  logic [1:0] codes [3] = '{SEL_SHUTDOWN, SEL_BIPOLAR, SEL_UNIPOLAR};
  int bad_count, n_tests, nHi, nLo;
  bit inCal;

  sasc_host u_host (.shiftOn(shiftOn), .convClk(convClk),
    .shiftClk(shiftClk), .compBit(compBit));
  sasc_top #(.CAL_LEN(CAL)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .convClk(convClk), .shiftClk(shiftClk), .chipSel_n(chipSel_n),
    .convert_start_n(convert_start_n), .reset_n(reset_n),
    .range_shutdown_select(range_shutdown_select), .compBit(compBit),
    .endOfConv(endOfConv), .dataOut(dataOut), .dataOut_oe_n(dataOut_oe_n),
    .bipolar(bipolar), .shutdown(shutdown), .settled(settled));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // decisions taken while the end flag frames them
  always @(negedge convClk) begin
    if (endOfConv === 1'b1) begin
      nHi++;
      bits = {bits[12:0], compBit};
      if (!inCal) begin
        tick(5);
        check("bit stream", dataOut, bits[0]);
      end
    end else begin
      nLo++;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic wait_eoc(input logic lvl);
    int k;
    k = 0;
    while (endOfConv !== lvl && k < 2000) begin
      tick(1);
      k++;
    end
    check("end flag wait", k < 2000, 1'b1);
  endtask : wait_eoc

  task automatic pulse;
    convert_start_n <= 1'b0;
    tick($urandom_range(6, 3));
    convert_start_n <= 1'b1;
  endtask : pulse

  // late: issued right after the previous end, so acquisition runs out
  task automatic convert(input bit late, input bit extra);
    if (!late) begin
      @(negedge convClk);
      tick(1);
    end
    nLo = 0;
    nHi = 0;
    pulse();
    wait_eoc(1'b1);
    check("start falls", nLo, late ? 4 : 1);
    if (extra) begin
      tick(20);
      pulse();
    end
    wait_eoc(1'b0);
    check("bit count", nHi, RESULT_BITS);
    if (extra) begin
      tick(60);
      check("no restart", endOfConv, 1'b0);
    end
  endtask : convert

  task automatic readout;
    logic [13:0] got;
    chipSel_n <= 1'b0;
    tick(4);
    check("oe on", dataOut_oe_n, 1'b0);
    shiftOn <= 1'b1;
    for (int i = 0; i < RESULT_BITS; i++) begin
      @(negedge shiftClk);
      if (i == RESULT_BITS - 1) begin
        shiftOn <= 1'b0;
      end
      tick(5);
      got = {got[12:0], dataOut};
    end
    check("serial word", got, bits);
    chipSel_n <= 1'b1;
    tick(4);
    check("oe off", dataOut_oe_n, 1'b1);
  endtask : readout

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #1_000_000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    bits = 14'($urandom(32'h0000_05a9));
    {sys_rst, convert_start_n, chipSel_n} <= 3'h7;
    {reset_n, shiftOn} <= 2'h0;
    range_shutdown_select <= SEL_UNIPOLAR;
    tick(10);
    sys_rst <= 1'b0;
    tick(40);
    check("idle in reset", endOfConv, 1'b0);
    @(negedge convClk);
    tick(1);
    inCal = 1'b1;
    nHi = 0;
    reset_n <= 1'b1;
    wait_eoc(1'b1);
    wait_eoc(1'b0);
    inCal = 1'b0;
    check("cal falls", nHi, CAL);
    $display("test calibration done");
    for (int i = 0; i < 3; i++) begin
      range_shutdown_select <= codes[i];
      tick(6);
      check("shutdown", shutdown, codes[i] == SEL_SHUTDOWN);
      check("bipolar", bipolar, codes[i] == SEL_BIPOLAR);
    end
    check("settled early", settled, 1'b0);
    tick(TSU_CYC);
    check("settled", settled, 1'b1);
    $display("test range select done");
    for (int i = 0; i < 4; i++) begin
      convert(1'b0, 1'b0);
      convert(1'b1, 1'b1);
      readout();
      $display("test conversion pair %0d done", i);
    end
    // halt mid-conversion, then a second calibration
    convert_start_n <= 1'b0;
    wait_eoc(1'b1);
    convert_start_n <= 1'b1;
    tick(30);
    reset_n <= 1'b0;
    tick(6);
    check("halt", endOfConv, 1'b0);
    @(negedge convClk);
    tick(1);
    inCal = 1'b1;
    nHi = 0;
    reset_n <= 1'b1;
    wait_eoc(1'b1);
    wait_eoc(1'b0);
    inCal = 1'b0;
    check("recal falls", nHi, CAL);
    $display("test device reset done");
    report_and_stop();
  end
endmodule : tb_top
